// ==== hw/lss_sequencer.sv ====
// LCD multi-rail supply sequencer with fault supervision
`include "lss_consts.svh"
module lss_sequencer
#(
    parameter int FILT_CYC = `LSS_FILT_CYC
)
(
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Pins and analog comparator flags, asynchronous
    input  wire logic        primary_enable,
    input  wire logic        secondary_enable,
    input  wire logic        panel_mode_input,
    input  wire logic        frequency_select,
    input  wire logic        vin_above_undervoltage_lockout,
    input  wire logic        over_temp,
    input  wire logic        internal_regulator_out_ok,
    input  wire logic        ref_in_range,
    input  wire logic        buck_ok,
    input  wire logic        neg_pump_ok,
    input  wire logic        boost_ok,
    input  wire logic        pos_pump_ok,
    input  wire logic        switch_ok,
    input  wire logic        modulated_gate_output_high,
    input  wire logic        stepdown_softstart_ramp_2v,
    input  wire logic        first_delay_ramp_done,
    input  wire logic        first_delay_ramp_2v,
    input  wire logic        first_delay_pin_open,
    input  wire logic        boost_softstart_ramp_2v,
    input  wire logic        second_delay_ramp_done,
    input  wire logic        second_delay_ramp_2v,
    input  wire logic        second_delay_pin_open,
    // Power stage enables and switching clocks
    output logic             regulator_en,
    output logic             ref_en,
    output logic             buck_en,
    output logic             first_delay_en,
    output logic             neg_pump_en,
    output logic             soft_connect_pin,
    output logic             boost_en,
    output logic             second_delay_en,
    output logic             pos_pump_en,
    output logic             gate_pulse_modulator,
    output logic             sw_clk,
    output logic             pump_clk
);
    import lss_pkg::*;

    localparam int NS = 21;
    localparam int CW = $clog2(FILT_CYC + 1);

    // Elaboration check: the filter needs at least two counts
    generate
        if (FILT_CYC < 2)
        begin
            $error("FILT_CYC too small");
        end
    endgenerate

    typedef struct packed {
        logic [NS-1:0]  s1;
        logic [NS-1:0]  s2;
        lss_state_t     st;
        logic           fault_latch;
        logic [CW-1:0]  filt_cnt;
        logic [9:0]     sw_cnt;
        logic           sw_clk;
        logic           pump_clk;
        logic           gpm_miss;
        logic [1:0]     gpm_misses;
        logic           gpm_fault;
        logic           sw_prev;
        logic [4:0]     flt_seen;
        logic           force_off;
        logic [11:0]    outs;
        logic [31:0]    rdata;
        logic           wait_n;
    } lss_regs_t;

    lss_regs_t cur_reg;
    lss_regs_t cur_next;
    logic      rst_s1_reg;
    logic      rst_n_reg;
    logic [NS-1:0] raw;
    logic [NS-1:0] sy;

    // Reset release synchroniser
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    assign raw = {primary_enable, secondary_enable, panel_mode_input,
                  frequency_select, vin_above_undervoltage_lockout, over_temp,
                  internal_regulator_out_ok, ref_in_range, buck_ok,
                  neg_pump_ok, boost_ok, pos_pump_ok, switch_ok,
                  modulated_gate_output_high, stepdown_softstart_ramp_2v,
                  first_delay_ramp_done, first_delay_ramp_2v,
                  first_delay_pin_open, boost_softstart_ramp_2v,
                  second_delay_ramp_done, second_delay_ramp_2v};

    // Synchronised views of the inputs, second stage only
    logic en1, en2, pmode, fsel, vin_ok, otemp, reg_ok, ref_ok;
    logic bk_ok, np_ok, bo_ok, pp_ok, sw_ok, gate_hi;
    logic ssb2v, d1done, d1_2v, d1open, ss2v, d2done, d2_2v;
    assign sy = cur_reg.s2;
    assign {en1, en2, pmode, fsel, vin_ok, otemp, reg_ok, ref_ok,
            bk_ok, np_ok, bo_ok, pp_ok, sw_ok, gate_hi, ssb2v, d1done,
            d1_2v, d1open, ss2v, d2done, d2_2v} = sy;

    // Second-delay pin is static strap, synchronised separately
    logic d2open_s1_reg, d2open_reg;
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            d2open_s1_reg <= 1'b0;
            d2open_reg    <= 1'b0;
        end
        else if (clk_en)
        begin
            d2open_s1_reg <= second_delay_pin_open;
            d2open_reg    <= d2open_s1_reg;
        end
    end

    // Switching half-period select
    function automatic logic [9:0] half_period(input logic hi);
        half_period = hi ? 10'(`LSS_SW_HALF_HI) : 10'(`LSS_SW_HALF_LO);
    endfunction

    logic [4:0] fchk, fraw;
    logic       any_fault, thermal_lock, pump_on;
    logic [11:0] o;

    // Next-state logic
    always_comb
    begin
        cur_next    = cur_reg;
        cur_next.s1 = raw;
        cur_next.s2 = cur_reg.s1;
        // Oscillator and pump clock
        if (cur_reg.sw_cnt >= half_period(fsel) - 10'h001)
        begin
            cur_next.sw_cnt = 10'h000;
            cur_next.sw_clk = !cur_reg.sw_clk;
            if (!cur_reg.sw_clk)
                cur_next.pump_clk = !cur_reg.pump_clk;
        end
        else
            cur_next.sw_cnt = cur_reg.sw_cnt + 10'h001;
        // Modulator output checked each oscillator period: a period
        // counts as missed only if the output never reached the rail
        cur_next.sw_prev = cur_reg.sw_clk;
        cur_next.gpm_miss = cur_reg.gpm_miss & !gate_hi;
        if (cur_reg.sw_clk && !cur_reg.sw_prev)
        begin
            cur_next.gpm_miss = 1'b1;
            cur_next.gpm_misses = (cur_reg.gpm_miss & cur_reg.outs[2])
                ? ((cur_reg.gpm_misses == 2'h2) ? 2'h2
                   : cur_reg.gpm_misses + 2'h1) : 2'h0;
        end
        cur_next.gpm_fault = (cur_reg.gpm_misses == 2'h2);
        // Fault flags gated by ramp thresholds
        fraw = {!bk_ok, !np_ok, !(bo_ok & sw_ok),
                !pp_ok | cur_reg.gpm_fault, 1'b0};
        fchk = {ssb2v, d1_2v, ss2v, d2_2v, 1'b0};
        any_fault = |(fraw & fchk) && cur_reg.st == LSS_RUN;
        if (any_fault)
            cur_next.filt_cnt = (cur_reg.filt_cnt == CW'(FILT_CYC))
                ? cur_reg.filt_cnt : cur_reg.filt_cnt + CW'(1);
        else
            cur_next.filt_cnt = '0;
        cur_next.flt_seen = cur_reg.flt_seen | (fraw & fchk);
        thermal_lock = otemp | !vin_ok;
        // Sequencer
        case (cur_reg.st)
            LSS_OFF:
                if (en1 && vin_ok && !cur_reg.force_off)
                    cur_next.st = LSS_REG_UP;
            LSS_REG_UP:
                if (reg_ok)
                    cur_next.st = LSS_REF_UP;
            LSS_REF_UP:
                if (ref_ok)
                    cur_next.st = LSS_BUCK;
            LSS_BUCK, LSS_RUN:
                if (!ref_ok)
                    cur_next.st = LSS_REF_UP;
                else
                    cur_next.st = LSS_RUN;
            LSS_SHUT:
                if (!thermal_lock)
                    cur_next.st = LSS_REF_UP;
            LSS_FAULT:
                if (!reg_ok)
                    cur_next.st = LSS_OFF;
            default:
                cur_next.st = LSS_OFF;
        endcase
        if (cur_reg.st != LSS_OFF && cur_reg.st != LSS_FAULT
            && thermal_lock)
            cur_next.st = LSS_SHUT;
        if (cur_reg.filt_cnt == CW'(FILT_CYC - 1) && any_fault)
            cur_next.st = LSS_FAULT;
        cur_next.fault_latch = (cur_next.st == LSS_FAULT);
        if (!en1 || cur_reg.force_off)
            cur_next.st = LSS_OFF;
        // Output enables
        o = '0;
        o[11] = cur_next.st != LSS_OFF && cur_next.st != LSS_FAULT;
        o[10] = cur_next.st == LSS_REF_UP || cur_next.st == LSS_BUCK
              || cur_next.st == LSS_RUN;
        o[9] = cur_next.st == LSS_RUN;
        o[8] = o[9] & bk_ok;
        o[7] = o[8] & (d1done | d1open);
        pump_on = o[9] & en2 & cur_reg.outs[3];
        o[6] = o[9] & en2 & cur_reg.outs[6] | pump_on
             | o[9] & en2 & bk_ok;
        o[5] = o[6] & cur_reg.outs[6] & sw_ok;
        o[4] = o[5] & bo_ok;
        o[3] = o[4] & (d2done | d2open_reg);
        o[2] = o[3] & pmode & pp_ok;
        cur_next.outs = o;
        // Avalon-MM slave, one wait cycle per access
        cur_next.wait_n = (avs_read | avs_write) & !cur_reg.wait_n;
        if ((avs_read | avs_write) && !cur_reg.wait_n)
        begin
            cur_next.rdata = 32'h0000_0000;
            if (avs_read)
                case (avs_address)
                    `LSS_OFF_CTRL:   cur_next.rdata = {31'h0,
                                                       cur_reg.force_off};
                    `LSS_OFF_STATUS: cur_next.rdata = {16'h0,
                        cur_reg.fault_latch, 1'b0, 1'b0, cur_reg.st,
                        cur_reg.outs[11:2]};
                    `LSS_OFF_FAULTS: cur_next.rdata = {27'h0,
                                                       cur_reg.flt_seen};
                    default:         cur_next.rdata = 32'h0000_0000;
                endcase
        end
        // Writes land on the edge at which waitrequest is seen low
        if (avs_write && cur_reg.wait_n && avs_address == `LSS_OFF_CTRL)
        begin
            cur_next.force_off = avs_writedata[`LSS_CTRL_FORCE_OFF];
            if (avs_writedata[`LSS_CTRL_FLT_CLR])
                cur_next.flt_seen = fraw & fchk;  // set beats clear
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cur_reg       <= '0;
            cur_reg.st    <= LSS_OFF;
        end
        else if (!rst_n_reg)
            cur_reg       <= '0;
        else if (clk_en)
            cur_reg       <= cur_next;
    end

    assign avs_readdata         = cur_reg.rdata;
    assign avs_waitrequest      = !cur_reg.wait_n;
    assign regulator_en         = cur_reg.outs[11];
    assign ref_en               = cur_reg.outs[10];
    assign buck_en              = cur_reg.outs[9];
    assign first_delay_en       = cur_reg.outs[8];
    assign neg_pump_en          = cur_reg.outs[7];
    assign soft_connect_pin     = cur_reg.outs[6];
    assign boost_en             = cur_reg.outs[5];
    assign second_delay_en      = cur_reg.outs[4];
    assign pos_pump_en          = cur_reg.outs[3];
    assign gate_pulse_modulator = cur_reg.outs[2];
    assign sw_clk               = cur_reg.sw_clk;
    assign pump_clk             = cur_reg.pump_clk;

    // Assertions
    chk_buck_needs_ref: assert property (@(posedge clk_sys)
        disable iff (!rst_n_reg) buck_en |-> $past(ref_en))
        else $error("step-down on without reference");
    chk_boost_after_sw: assert property (@(posedge clk_sys)
        disable iff (!rst_n_reg) $rose(boost_en) |-> $past(soft_connect_pin))
        else $error("step-up before soft switch");
    chk_en1_off: assert property (@(posedge clk_sys)
        disable iff (!rst_n_reg) clk_en && !en1 |=> !regulator_en)
        else $error("primary enable low but regulator on");
    chk_gpm_gate: assert property (@(posedge clk_sys)
        disable iff (!rst_n_reg) gate_pulse_modulator |-> pos_pump_en)
        else $error("modulator without positive pump");
    chk_undervoltage_lockout_start: assert property (@(posedge clk_sys)
        disable iff (!rst_n_reg) $rose(regulator_en) |-> $past(vin_ok))
        else $error("start below lockout");
    chk_thermal_off: assert property (@(posedge clk_sys)
        disable iff (!rst_n_reg) clk_en && otemp && en1
        && cur_reg.st == LSS_RUN && !cur_reg.force_off |=> !buck_en)
        else $error("thermal shutdown missed");
    chk_fault_off: assert property (@(posedge clk_sys)
        disable iff (!rst_n_reg) cur_reg.fault_latch |-> !regulator_en)
        else $error("regulator on with fault latch");
    chk_pos_pump: assert property (@(posedge clk_sys)
        disable iff (!rst_n_reg) pos_pump_en |-> second_delay_en)
        else $error("positive pump before second delay");
endmodule

// ==== hw/lss_consts.svh ====
// Constants for the LCD supply sequencer: bus offsets, fields and timing
`ifndef LSS_CONSTS_SVH
`define LSS_CONSTS_SVH
`define LSS_CLK_MHZ          250
`define LSS_FILT_NS          63000
`define LSS_FILT_CYC         ((`LSS_FILT_NS * `LSS_CLK_MHZ) / 1000)
`define LSS_OSC_LO_KHZ       650
`define LSS_OSC_HI_KHZ       1300
`define LSS_SW_HALF_LO       ((`LSS_CLK_MHZ * 1000) / (2 * `LSS_OSC_LO_KHZ))
`define LSS_SW_HALF_HI       ((`LSS_CLK_MHZ * 1000) / (2 * `LSS_OSC_HI_KHZ))
`define LSS_OFF_CTRL         4'h0
`define LSS_OFF_STATUS       4'h4
`define LSS_OFF_FAULTS       4'h8
`define LSS_CTRL_RESET       32'h0000_0000
`define LSS_CTRL_FORCE_OFF   0
`define LSS_CTRL_FLT_CLR     1
`endif

// ==== hw/lss_pkg.sv ====
// Types for the LCD supply sequencer
package lss_pkg;
    // Sequencer states, Gray coded along the start-up path
    typedef enum logic [2:0] {
        LSS_OFF    = 3'b000,
        LSS_REG_UP = 3'b001,
        LSS_REF_UP = 3'b011,
        LSS_BUCK   = 3'b010,
        LSS_RUN    = 3'b110,
        LSS_SHUT   = 3'b111,
        LSS_FAULT  = 3'b101
    } lss_state_t;
endpackage

// ==== testbench/lss_analog_model.sv ====
// Behavioural model of the rail comparators and ramps around the sequencer
module lss_analog_model
#(
    parameter int LAG = 6
)
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Stage enables and test controls
    input  wire logic [10:0] stage_en,
    input  wire logic        slow,
    input  wire logic [10:0] flag_kill,
    // Comparator and ramp flags
    output logic      [10:0] flag_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt [11];
    // Settling time counted from each stage enable
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        for (int i = 0; i < 11; i++)
        begin
            if (!arst_n || !stage_en[i])
                cnt[i] <= 0;
            else if (cnt[i] < 255)
                cnt[i] <= cnt[i] + 1;
        end
    end
    // A stage that is off or killed reads as out of regulation
    always_comb
    begin
        for (int i = 0; i < 11; i++)
            flag_ok[i] = stage_en[i] && !flag_kill[i]
                         && cnt[i] >= (slow ? 4 * LAG : LAG);
    end
endmodule

// ==== testbench/lss_sequencer_tb_top.sv ====
// Self-checking testbench for the LCD supply sequencer
`include "lss_consts.svh"
module lss_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // Filter longer than a slow pump start, so start-up is no fault
    localparam int FILT = 40;
    logic        clk_sys, arst_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, rv;
    logic        primary_enable, secondary_enable, panel_mode_input;
    logic        frequency_select, vin_above_undervoltage_lockout, over_temp, slow;
    logic        first_delay_pin_open, second_delay_pin_open;
    logic [10:0] kill, flag;
    logic [11:0] outs;
    int          num_errors, total_checks, n, m;
    int          seed = 32'hf97d;

    lss_sequencer #(.FILT_CYC(FILT)) dut
    (
        .clk_sys, .arst_n, .clk_en(1'b1), .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .primary_enable, .secondary_enable, .panel_mode_input,
        .frequency_select, .vin_above_undervoltage_lockout, .over_temp,
        .internal_regulator_out_ok(flag[0]), .ref_in_range(flag[1]),
        .buck_ok(flag[2]), .stepdown_softstart_ramp_2v(flag[3]),
        .first_delay_ramp_done(flag[4]), .first_delay_ramp_2v(flag[4]),
        .neg_pump_ok(flag[5]), .switch_ok(flag[6]), .boost_ok(flag[7]),
        .boost_softstart_ramp_2v(flag[7]), .second_delay_ramp_done(flag[8]),
        .second_delay_ramp_2v(flag[8]), .pos_pump_ok(flag[9]),
        .modulated_gate_output_high(flag[10]), .first_delay_pin_open,
        .second_delay_pin_open, .regulator_en(outs[0]), .ref_en(outs[1]),
        .buck_en(outs[2]), .first_delay_en(outs[3]), .neg_pump_en(outs[4]),
        .soft_connect_pin(outs[5]), .boost_en(outs[6]),
        .second_delay_en(outs[7]), .pos_pump_en(outs[8]),
        .gate_pulse_modulator(outs[9]), .sw_clk(outs[10]), .pump_clk(outs[11])
    );
    lss_analog_model model
    (
        .clk_sys, .arst_n, .slow, .flag_kill(kill), .flag_ok(flag),
        .stage_en({outs[9:2], outs[2:0]})
    );

    // Free-running system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic cyc(int k);
        repeat (k) @(posedge clk_sys);
    endtask

    task automatic check_val(string what, logic [31:0] exp, logic [31:0] got);
    begin
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    task automatic check_span(string what, int lo, int hi, int got);
    begin
        total_checks++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    end
    endtask

    // One bus access, held until waitrequest is sampled low
    task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
        int k;
    begin
        k = 0;
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 50);
        check_span("bus_wait", 1, 49, k);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    end
    endtask

    task automatic wait_out(string what, int i, logic v, int lim);
        int k;
    begin
        k = 0;
        while (outs[i] !== v && k < lim)
        begin
            @(posedge clk_sys);
            k++;
        end
        check_val(what, {31'h0, v}, {31'h0, outs[i]});
    end
    endtask

    // High time of an oscillator output, in system clocks
    task automatic high_time(int i, output int k);
    begin
        k = 0;
        while (outs[i] !== 1'b0 && k < 2000)
            cyc(1);
        while (outs[i] !== 1'b1 && k < 2000)
        begin
            cyc(1);
            k++;
        end
        k = 0;
        while (outs[i] === 1'b1 && k < 2000)
        begin
            cyc(1);
            k++;
        end
    end
    endtask

    // Full start-up with both enables, with or without delay capacitors
    task automatic power_up(logic open);
    begin
        first_delay_pin_open  <= open;
        second_delay_pin_open <= open;
        kill[4] <= open;
        kill[8] <= open;
        slow <= !open;
        panel_mode_input <= 1'b1;
        secondary_enable <= 1'b1;
        primary_enable   <= 1'b1;
        for (n = 0; n < 600 && flag[2] !== 1'b1; n++)
            cyc(1);
        check_val("switch_early", 32'h0, {31'h0, outs[5] | outs[6]});
        wait_out("neg_pump", 4, 1'b1, 400);
        wait_out("pos_pump", 8, 1'b1, 600);
        wait_out("modulator", 9, 1'b1, 300);
        bus(1'b0, `LSS_OFF_STATUS, 32'h0);
        check_val("status_run", 32'h0000_1bff, rd);
    end
    endtask

    // Start-up order among the enables, every cycle
    always @(posedge clk_sys)
        if (arst_n)
            check_val("order", 32'h0, {31'h0, (outs[1] & !outs[0])
                | (outs[2] & !outs[1]) | (outs[4] & !outs[2])
                | (outs[6] & !outs[5]) | (outs[8] & !outs[6])
                | (outs[9] & !outs[8])});

    task automatic print_verdict;
    begin
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask

    // Watchdog against a hang
    initial
    begin
        cyc(60000);
        num_errors++;
        print_verdict();
    end

    initial
    begin
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {primary_enable, secondary_enable, panel_mode_input} = '0;
        {frequency_select, over_temp, slow, kill} = '0;
        {first_delay_pin_open, second_delay_pin_open} = '0;
        vin_above_undervoltage_lockout = 1'b0;
        num_errors = 0;
        total_checks = 0;
        arst_n = 1'b0;
        cyc(12);
        arst_n <= 1'b1;
        cyc(3);
        bus(1'b0, `LSS_OFF_CTRL, 32'h0);
        check_val("ctrl_reset", `LSS_CTRL_RESET, rd);
        bus(1'b0, `LSS_OFF_STATUS, 32'h0);
        check_val("status_reset", 32'h0, rd);
        bus(1'b1, 4'hc, 32'hffff_ffff);
        bus(1'b0, 4'hc, 32'h0);
        check_val("unmapped", 32'h0, rd);
        primary_enable <= 1'b1;
        cyc(60);
        check_val("undervoltage_lockout_hold", 32'h0, {30'h0, outs[2:1]});
        vin_above_undervoltage_lockout <= 1'b1;
        power_up(1'b0);
        secondary_enable <= 1'b0;
        wait_out("boost_off", 6, 1'b0, 5);
        check_val("pos_off", 32'h0, {30'h0, outs[9:8]});
        check_val("buck_kept", 32'h1, {31'h0, outs[2]});
        secondary_enable <= 1'b1;
        wait_out("pos_back", 8, 1'b1, 400);
        panel_mode_input <= 1'b0;
        wait_out("mod_panel", 9, 1'b0, 5);
        panel_mode_input <= 1'b1;
        kill[1] <= 1'b1;
        wait_out("ref_bad", 2, 1'b0, 5);
        kill[1] <= 1'b0;
        wait_out("ref_back", 4, 1'b1, 400);
        for (m = 0; m < 2; m++)
        begin
            if (m == 0)
                over_temp <= 1'b1;
            else
                vin_above_undervoltage_lockout <= 1'b0;
            wait_out("shut", 2, 1'b0, 5);
            check_val("reg_kept", 32'h1, {31'h0, outs[0]});
            over_temp <= 1'b0;
            vin_above_undervoltage_lockout <= 1'b1;
            wait_out("restart", 4, 1'b1, 400);
        end
        kill[2] <= 1'b1;
        cyc(FILT - 4);
        check_val("filter", 32'h1, {31'h0, outs[0]});
        wait_out("latch", 0, 1'b0, 12);
        bus(1'b0, `LSS_OFF_FAULTS, 32'h0);
        check_val("fault_buck", 32'h1, {31'h0, rd[4]});
        kill[2] <= 1'b0;
        wait_out("auto_restart", 0, 1'b1, 30);
        wait_out("restart_neg", 4, 1'b1, 400);
        wait_out("restart_pos", 8, 1'b1, 600);
        cyc(40);
        bus(1'b1, `LSS_OFF_CTRL, 32'h2);
        bus(1'b0, `LSS_OFF_FAULTS, 32'h0);
        check_val("fault_clr", 32'h0, rd);
        for (m = 0; m < 2; m++)
        begin
            frequency_select <= m[0];
            cyc(800);
            n = m ? `LSS_SW_HALF_HI : `LSS_SW_HALF_LO;
            high_time(10, n);
            high_time(10, n);
            check_span("sw_half", (m ? `LSS_SW_HALF_HI : `LSS_SW_HALF_LO) - 1,
                (m ? `LSS_SW_HALF_HI : `LSS_SW_HALF_LO) + 1, n);
            high_time(11, n);
            check_span("pump_half", (m ? `LSS_SW_HALF_HI : `LSS_SW_HALF_LO) * 2
                - 2, (m ? `LSS_SW_HALF_HI : `LSS_SW_HALF_LO) * 2 + 2, n);
        end
        for (m = 0; m < 30; m++)
        begin
            rv = $random(seed);
            secondary_enable <= rv[0];
            panel_mode_input <= rv[1];
            cyc(rv[7:2] + 1);
        end
        primary_enable <= 1'b0;
        wait_out("prim_off", 0, 1'b0, 5);
        check_val("all_off", 32'h0, {22'h0, outs[9:0]});
        power_up(1'b1);
        print_verdict();
    end
endmodule
